// ===== ext_mem_pkg.sv
// shared constants, register map and types of the external memory bus interface
package ext_mem_pkg;

    // register byte offsets on the apb side
    localparam logic [7:0] OFF_MCU_CONTROL = 8'h00;
    localparam logic [7:0] OFF_EXT_MCU_CONTROL = 8'h04;
    localparam logic [7:0] OFF_SPECIAL_FUNC_IO = 8'h08;
    localparam logic [7:0] OFF_AD_PORT = 8'h0C;
    localparam logic [7:0] OFF_AD_DIR = 8'h10;
    localparam logic [7:0] OFF_HI_PORT = 8'h14;
    localparam logic [7:0] OFF_HI_DIR = 8'h18;
    localparam logic [7:0] OFF_CTL_PORT = 8'h1C;
    localparam logic [7:0] OFF_CTL_DIR = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;

    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [2:0] RST_REG3 = 3'h0;

    // mcu_control fields
    localparam int BUS_IFACE_ENABLE_POS = 7;
    localparam int UPPER_WAIT_BIT0_POS = 6;
    // ext_mcu_control fields
    localparam int SECTOR_LIMIT_LSB = 4;
    localparam int LOWER_WAIT_BIT1_POS = 3;
    localparam int LOWER_WAIT_BIT0_POS = 2;
    localparam int UPPER_WAIT_BIT1_POS = 1;
    // special_func_io fields
    localparam int KEEPER_ENABLE_POS = 6;
    localparam int HIGH_ADDR_MASK_LSB = 3;
    // control pin bit positions in ctl port/dir registers
    localparam int CTL_ALE_POS = 2;
    localparam int CTL_RD_POS = 1;
    localparam int CTL_WR_POS = 0;

    // last internal data-space address
    localparam logic [15:0] INT_TOP_ADDR = 16'h025F;
    // extra strobe cycles a read spends so the synchronised pins reflect the data
    localparam logic [3:0] SYNC_LAT = 4'h2;

    // wait codes, then the keep-none high address mask code and the one-sector limit code
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [1:0] WAIT_TWO = 2'h2;
    localparam logic [1:0] WAIT_TWO_RECOV = 2'h3;
    localparam logic [2:0] MASK_KEEP_NONE = 3'h7;
    localparam logic [2:0] LIMIT_ONE_SECTOR = 3'h0;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_LATCH = 3'b010,
        S_STRB = 3'b011,
        S_RECOV = 3'b100,
        S_END = 3'b101,
        S_INT = 3'b110
    } state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic we;
        logic [7:0] wdata;
        logic next_data;
    } acc_req_t;

endpackage

// ===== sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ===== ext_memory_bus_interface.sv
// multiplexed external memory bus controller with apb register file
//
// Function
// R1: enable bit 7 of mcu_control switches bus pins to memory functions
// R2: while enabled, interface owns pin direction regardless of direction registers
// R3: clearing enable returns pins to port values and direction settings
// R4: each access decoded internal or external; external drives address, data, strobes
// R5: low address byte valid on shared lines when latch strobe falls
// R6: latch strobe stays low through the whole data transfer phase
// R7: internal access may move address and latch strobe, never read/write strobes
// R8: when disabled, addresses above internal sram never alias into it
// R9: low address and data share eight lines; high address width configurable
// R10: keeper holds last driven value on shared lines while tri-stated
// R11: shared-line pull-ups active where matching port output bits are one
// R12: four software-selected wait settings, including zero wait
// R13: external space splits into two sectors with own wait setting
// R14: trailing latch-strobe pulse in final period only if next access is data
// R15: mcu_control bit 6 holds upper sector wait low bit
// R16: each sector's wait code built from its own pair of select bits
// R17: wait 00 none, 01 one, 10 two, 11 two plus recovery cycle
// R18: sector limit zero means one upper sector, else 8 KB boundary steps
// R19: high address mask releases top high-address pins; 000 keeps all, 111 none
// R20: keeper enable acts even while interface disabled
// R21: strobe stretched by the wait cycles of the addressed sector
// R22: external latch transparent on strobe high, holds after fall
`timescale 1ns/1ps
`default_nettype none
module ext_memory_bus_interface
    import ext_mem_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acc_valid,
    input wire acc_req_t acc,
    output logic acc_busy,
    output logic acc_done,
    output logic acc_internal,
    output logic [7:0] acc_rdata,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    output logic ad_keeper_on,
    output logic [7:0] ad_pullup,
    output logic [7:0] hi_out,
    output logic [7:0] hi_oe,
    output logic ale_out,
    output logic ale_oe,
    output logic rd_n_out,
    output logic rd_n_oe,
    output logic wr_n_out,
    output logic wr_n_oe
);
    logic [7:0] mcu_ff, emcu_ff, sfio_ff;
    logic [7:0] ad_port_ff, ad_dir_ff, hi_port_ff, hi_dir_ff;
    logic [2:0] ctl_port_ff, ctl_dir_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;
    state_t state_ff, nxt_state;
    acc_req_t req_ff, cur_req;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [1:0] wcode_ff, sel_wcode;
    logic upper_ff, ext_ff, int_ff, busy_ff, done_ff, internal_ff;
    logic [7:0] rdata_ff, ad_sync;
    logic [7:0] ad_out_ff, ad_pullup_ff, hi_out_ff, hi_oe_ff;
    logic ad_oe_ff, keeper_ff;
    logic ale_ff, ale_oe_ff, rd_n_ff, rd_n_oe_ff, wr_n_ff, wr_n_oe_ff;
    logic en, acc_is_int, sel_upper, take, setup, wr_go, hit;
    logic [2:0] limit, hmask;
    logic [1:0] up_code, lo_code;
    logic [7:0] keep_mask, b_ad, rd_mux;
    logic b_ad_oe, b_ale, b_rd_n, b_wr_n;

    sync2 #(.W(8)) u_ad_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(ad_in),
        .q(ad_sync)
    );

    assign en = mcu_ff[BUS_IFACE_ENABLE_POS];
    assign limit = emcu_ff[SECTOR_LIMIT_LSB +: 3];
    assign hmask = sfio_ff[HIGH_ADDR_MASK_LSB +: 3];
    assign up_code = {emcu_ff[UPPER_WAIT_BIT1_POS], mcu_ff[UPPER_WAIT_BIT0_POS]}; // [R15] [R16]
    assign lo_code = {emcu_ff[LOWER_WAIT_BIT1_POS], emcu_ff[LOWER_WAIT_BIT0_POS]}; // [R16]
    assign acc_is_int = acc.addr <= INT_TOP_ADDR; // [R4] [R8]
    assign sel_upper = (limit == LIMIT_ONE_SECTOR) || (acc.addr[15:13] >= limit); // [R18] [R13]
    assign sel_wcode = sel_upper ? up_code : lo_code; // [R21]
    assign take = acc_valid && (state_ff == S_IDLE);

    // strobe cycles minus one for a wait code
    function automatic logic [3:0] wait_extra(input logic [1:0] code);
        unique case (code)
            WAIT_NONE: wait_extra = 4'h0;
            WAIT_ONE: wait_extra = 4'h1;
            WAIT_TWO: wait_extra = 4'h2;
            WAIT_TWO_RECOV: wait_extra = 4'h2;
        endcase
    endfunction

    // high address pins kept by the mask code
    always_comb begin
        if (hmask == MASK_KEEP_NONE) begin
            keep_mask = 8'h00; // [R19]
        end else begin
            keep_mask = 8'hFF >> hmask; // [R19] [R9]
        end
    end

    // ---------------- apb slave ----------------
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready_ff && pwrite;

    always_comb begin
        hit = 1'b1;
        rd_mux = 8'h00;
        unique case (paddr)
            OFF_MCU_CONTROL: rd_mux = mcu_ff;
            OFF_EXT_MCU_CONTROL: rd_mux = emcu_ff;
            OFF_SPECIAL_FUNC_IO: rd_mux = sfio_ff;
            OFF_AD_PORT: rd_mux = ad_port_ff;
            OFF_AD_DIR: rd_mux = ad_dir_ff;
            OFF_HI_PORT: rd_mux = hi_port_ff;
            OFF_HI_DIR: rd_mux = hi_dir_ff;
            OFF_CTL_PORT: rd_mux = {5'h00, ctl_port_ff};
            OFF_CTL_DIR: rd_mux = {5'h00, ctl_dir_ff};
            OFF_STATUS: rd_mux = {4'h0, int_ff, ext_ff, upper_ff, busy_ff};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !hit;
            if (setup) begin
                prdata_ff <= (paddr == OFF_STATUS) ? {16'h0000, ad_sync, rd_mux} :
                             {24'h00_0000, rd_mux};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcu_ff <= RST_REG8;
            emcu_ff <= RST_REG8;
            sfio_ff <= RST_REG8;
            ad_port_ff <= RST_REG8;
            ad_dir_ff <= RST_REG8;
            hi_port_ff <= RST_REG8;
            hi_dir_ff <= RST_REG8;
            ctl_port_ff <= RST_REG3;
            ctl_dir_ff <= RST_REG3;
        end else if (wr_go) begin
            unique case (paddr)
                OFF_MCU_CONTROL: mcu_ff <= pwdata[7:0];
                OFF_EXT_MCU_CONTROL: emcu_ff <= pwdata[7:0];
                OFF_SPECIAL_FUNC_IO: sfio_ff <= pwdata[7:0];
                OFF_AD_PORT: ad_port_ff <= pwdata[7:0];
                OFF_AD_DIR: ad_dir_ff <= pwdata[7:0];
                OFF_HI_PORT: hi_port_ff <= pwdata[7:0];
                OFF_HI_DIR: hi_dir_ff <= pwdata[7:0];
                OFF_CTL_PORT: ctl_port_ff <= pwdata[2:0];
                OFF_CTL_DIR: ctl_dir_ff <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ---------------- access sequencer ----------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (take) begin
                    nxt_state = (en && !acc_is_int) ? S_ADDR : S_INT; // [R4] [R8]
                end
            end
            S_ADDR: nxt_state = S_LATCH;
            S_LATCH: begin
                nxt_state = S_STRB;
                nxt_cnt = wait_extra(wcode_ff) + (req_ff.we ? 4'h0 : SYNC_LAT); // [R12] [R21]
            end
            S_STRB: begin
                if (cnt_ff != 4'h0) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else begin
                    nxt_state = (wcode_ff == WAIT_TWO_RECOV) ? S_RECOV : S_END; // [R17]
                end
            end
            S_RECOV: nxt_state = S_END;
            S_END: nxt_state = S_IDLE;
            S_INT: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;
            cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff <= '0;
            wcode_ff <= WAIT_NONE;
            upper_ff <= 1'b0;
            ext_ff <= 1'b0;
            int_ff <= 1'b0;
        end else if (take) begin
            req_ff <= acc;
            wcode_ff <= sel_wcode; // [R13] [R21]
            upper_ff <= sel_upper;
            ext_ff <= en && !acc_is_int;
            int_ff <= acc_is_int;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            internal_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            busy_ff <= nxt_state != S_IDLE;
            done_ff <= (state_ff == S_END) || (state_ff == S_INT);
            internal_ff <= int_ff;
            if (take) begin
                rdata_ff <= 8'h00; // [R8]
            end else if (state_ff == S_STRB && cnt_ff == 4'h0 && !req_ff.we) begin
                rdata_ff <= ad_sync;
            end
        end
    end

    // ---------------- bus pin values for the entered state ----------------
    assign cur_req = take ? acc : req_ff;

    always_comb begin
        b_ad = cur_req.addr[7:0];
        b_ad_oe = 1'b0;
        b_ale = 1'b0;
        b_rd_n = 1'b1;
        b_wr_n = 1'b1;
        unique case (nxt_state)
            S_ADDR, S_INT: begin
                b_ad_oe = 1'b1;
                b_ale = 1'b1; // [R7]
            end
            S_LATCH: b_ad_oe = 1'b1; // [R5]
            S_STRB: begin
                b_ad = cur_req.wdata; // [R9]
                b_ad_oe = cur_req.we;
                b_rd_n = cur_req.we; // [R6] [R21]
                b_wr_n = !cur_req.we;
            end
            S_RECOV: begin
                b_ad = cur_req.wdata;
                b_ad_oe = cur_req.we;
            end
            S_END: begin
                b_ad = cur_req.wdata;
                b_ad_oe = cur_req.we;
                b_ale = cur_req.next_data; // [R14]
            end
            default: ;
        endcase
    end

    // pin multiplexers between bus and ordinary port functions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ad_out_ff <= 8'h00;
            ad_oe_ff <= 1'b0;
            ad_pullup_ff <= 8'h00;
            keeper_ff <= 1'b0;
        end else begin
            ad_oe_ff <= en ? b_ad_oe : ad_dir_ff[0]; // [R1] [R2] [R3]
            if (!en) begin
                ad_out_ff <= ad_port_ff; // [R3]
            end else if (b_ad_oe) begin
                ad_out_ff <= b_ad; // [R10]
            end
            ad_pullup_ff <= ad_port_ff & ~(en ? {8{b_ad_oe}} : ad_dir_ff); // [R11]
            keeper_ff <= sfio_ff[KEEPER_ENABLE_POS]; // [R20] [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_out_ff <= 8'h00;
            hi_oe_ff <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                hi_out_ff[i] <= (en && keep_mask[i]) ? cur_req.addr[8+i] : hi_port_ff[i]; // [R19]
                hi_oe_ff[i] <= (en && keep_mask[i]) ? 1'b1 : hi_dir_ff[i]; // [R2] [R3]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            ale_oe_ff <= 1'b0;
            rd_n_oe_ff <= 1'b0;
            wr_n_oe_ff <= 1'b0;
        end else begin
            ale_ff <= en ? b_ale : ctl_port_ff[CTL_ALE_POS]; // [R1] [R3]
            rd_n_ff <= en ? b_rd_n : ctl_port_ff[CTL_RD_POS];
            wr_n_ff <= en ? b_wr_n : ctl_port_ff[CTL_WR_POS];
            ale_oe_ff <= en || ctl_dir_ff[CTL_ALE_POS]; // [R2]
            rd_n_oe_ff <= en || ctl_dir_ff[CTL_RD_POS];
            wr_n_oe_ff <= en || ctl_dir_ff[CTL_WR_POS];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign acc_busy = busy_ff;
    assign acc_done = done_ff;
    assign acc_internal = internal_ff;
    assign acc_rdata = rdata_ff;
    assign ad_out = ad_out_ff;
    assign ad_oe = ad_oe_ff;
    assign ad_keeper_on = keeper_ff;
    assign ad_pullup = ad_pullup_ff;
    assign hi_out = hi_out_ff;
    assign hi_oe = hi_oe_ff;
    assign ale_out = ale_ff;
    assign ale_oe = ale_oe_ff;
    assign rd_n_out = rd_n_ff;
    assign rd_n_oe = rd_n_oe_ff;
    assign wr_n_out = wr_n_ff;
    assign wr_n_oe = wr_n_oe_ff;

    // ---------------- checks ----------------
    logic [3:0] strb_len_ff, exp_len_ff;
    logic strobe_low;
    assign strobe_low = !rd_n_ff || !wr_n_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strb_len_ff <= 4'h0;
            exp_len_ff <= 4'h0;
        end else begin
            strb_len_ff <= strobe_low ? strb_len_ff + 4'h1 : 4'h0;
            if (state_ff == S_LATCH) begin
                exp_len_ff <= nxt_cnt + 4'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_ext_start;
        state_ff == S_ADDR && ale_ff ##1 state_ff == S_LATCH;
    endsequence

    sequence seq_dis_ext;
        take && !en && !acc_is_int;
    endsequence

    a_latch_addr_valid: assert property ( // [R5]
        seq_ext_start and $past(en) |-> !ale_ff && ad_oe_ff && ad_out_ff == req_ff.addr[7:0])
        else $error("low address not valid at latch strobe fall");
    a_ale_low_xfer: assert property ( // [R6]
        (state_ff == S_STRB && $past(en)) |-> !ale_ff)
        else $error("latch strobe high during data transfer");
    a_int_no_strobe: assert property ( // [R7]
        (state_ff == S_INT && $past(en)) |-> rd_n_ff && wr_n_ff && ale_ff)
        else $error("strobe moved on internal access");
    a_no_alias: assert property ( // [R8]
        seq_dis_ext |=> state_ff == S_INT ##1 (acc_done && !acc_internal && acc_rdata == 8'h00))
        else $error("disabled external access aliased or hung");
    a_port_restore: assert property ( // [R3]
        $past(!en) |-> ad_oe_ff == $past(ad_dir_ff[0]) && ale_ff == $past(ctl_port_ff[CTL_ALE_POS]))
        else $error("pins not returned to port settings");
    a_dir_override: assert property ( // [R2]
        $past(en) |-> ale_oe_ff && rd_n_oe_ff && wr_n_oe_ff)
        else $error("control pin direction not overridden");
    a_strobe_len: assert property ( // [R21]
        ($fell(strobe_low) && $past(en, 2) && $past(en)) |-> strb_len_ff == exp_len_ff)
        else $error("strobe length differs from wait setting");
    a_recov_cycle: assert property ( // [R17]
        (state_ff == S_RECOV && $past(en)) |-> wcode_ff == WAIT_TWO_RECOV && rd_n_ff && wr_n_ff
            ##1 state_ff == S_END)
        else $error("recovery cycle without wait code 11");
    a_trailing_ale: assert property ( // [R14]
        (state_ff == S_END && $past(en)) |-> ale_ff == req_ff.next_data)
        else $error("trailing latch pulse wrong");
    a_hi_mask_none: assert property ( // [R19]
        $past(en && hmask == MASK_KEEP_NONE) |-> hi_oe_ff == $past(hi_dir_ff))
        else $error("high address pins not released");
    a_keeper_follow: assert property ( // [R20]
        ##1 ad_keeper_on == $past(sfio_ff[KEEPER_ENABLE_POS]))
        else $error("keeper not following its enable");

endmodule
`default_nettype wire

// ===== ext_mem_partner.sv
// behavioural address latch and sram on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_partner (
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic ad_keeper_on,
    input wire logic [7:0] ad_pullup,
    input wire logic [7:0] hi_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic rd_n_oe,
    input wire logic wr_n_out,
    input wire logic wr_n_oe,
    output logic [7:0] ad_in
);
    logic [7:0] mem [0:65535];
    logic [65535:0] stored = '0;
    logic [7:0] latch_q = 8'h00;
    logic [7:0] last_drv = 8'h00;
    logic [15:0] wr_addr = 16'h0000;
    // transparent while strobe high, holds after its fall
    always @* if (ale_out) latch_q = ad_out;
    always @* if (ad_oe) last_drv = ad_out;
    // address taken as the write strobe falls, so a trailing latch pulse cannot move it
    always @(negedge wr_n_out) wr_addr = {hi_out, latch_q};
    always @(posedge wr_n_out) begin
        if (ad_oe === 1'b1 && wr_n_oe === 1'b1) begin
            mem[wr_addr] = ad_out;
            stored[wr_addr] = 1'b1;
        end
    end
    always @* begin
        if (ad_oe) ad_in = ad_out;
        else if (rd_n_oe && !rd_n_out && stored[{hi_out, latch_q}]) ad_in = mem[{hi_out, latch_q}];
        else if (ad_keeper_on) ad_in = last_drv;
        else ad_in = ad_pullup | ~last_drv;
    end
endmodule
`default_nettype wire

// ===== test_external_memory_bus_interface.sv
// self-checking testbench of the external memory bus interface
`timescale 1ns/1ps
`default_nettype none
module test_external_memory_bus_interface;
    import ext_mem_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, acc_valid = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    acc_req_t acc = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, acc_busy, acc_done, acc_internal, err;
    logic [7:0] acc_rdata, ad_in, ad_out, ad_pullup, hi_out, hi_oe;
    logic ad_oe, ad_keeper_on, ale_out, ale_oe, rd_n_out, rd_n_oe, wr_n_out, wr_n_oe;
    int failures = 0, n_checks = 0, ale_cnt = 0, strb_cnt = 0, overlap = 0, lat, s, nbusy;
    always #50 pclk = ~pclk;
    ext_memory_bus_interface ext_memory_bus_interface_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid), .acc(acc),
        .acc_busy(acc_busy), .acc_done(acc_done), .acc_internal(acc_internal),
        .acc_rdata(acc_rdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .ad_keeper_on(ad_keeper_on), .ad_pullup(ad_pullup), .hi_out(hi_out), .hi_oe(hi_oe),
        .ale_out(ale_out), .ale_oe(ale_oe), .rd_n_out(rd_n_out), .rd_n_oe(rd_n_oe),
        .wr_n_out(wr_n_out), .wr_n_oe(wr_n_oe));
    ext_mem_partner ext_mem_partner_inst (.ad_out(ad_out), .ad_oe(ad_oe),
        .ad_keeper_on(ad_keeper_on), .ad_pullup(ad_pullup), .hi_out(hi_out),
        .ale_out(ale_out), .rd_n_out(rd_n_out), .rd_n_oe(rd_n_oe), .wr_n_out(wr_n_out),
        .wr_n_oe(wr_n_oe), .ad_in(ad_in));
    always @(posedge ale_out) ale_cnt++;
    always @(posedge pclk) begin
        if ((rd_n_oe & ~rd_n_out) | (wr_n_oe & ~wr_n_out)) strb_cnt++;
        if (ale_out & ((rd_n_oe & ~rd_n_out) | (wr_n_oe & ~wr_n_out))) overlap++;
    end
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic rdy;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer looked at once settled; the request is held through the next rising edge
        do begin
            #1; rdy = pready; rd = prdata; err = pslverr;
            @(posedge pclk); n++;
        end while (rdy !== 1'b1 && n < 20);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic xfer(input logic [15:0] a, input logic we, input logic [7:0] d, input logic nd);
        @(posedge pclk);
        acc_valid <= 1'b1; acc <= '{a, we, d, nd};
        @(posedge pclk);
        acc_valid <= 1'b0; lat = 1; nbusy = 0;
        // lat: cycle number of the done pulse, the cycle after the accept edge being 1
        do begin
            @(posedge pclk); #1; lat++;
            nbusy += int'(acc_busy === 1'b1);
        end while (acc_done !== 1'b1 && lat < 60);
    endtask
    function automatic int exp_lat(input logic we, input logic [1:0] c);
        return 5 + (c == WAIT_NONE ? 0 : (c == WAIT_ONE ? 1 : 2)) + (we ? 0 : int'(SYNC_LAT))
            + (c == WAIT_TWO_RECOV ? 1 : 0);
    endfunction
    initial begin
        tick(10);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin apb(0, 8'(4 * i), 0); chk(rd, 0); end
        apb(0, 8'h28, 0); chk({rd, err}, 33'h1);
        apb(1, OFF_CTL_PORT, 32'h3); apb(1, OFF_CTL_DIR, 32'h3);
        apb(1, OFF_AD_PORT, 32'h5A); apb(1, OFF_AD_DIR, 32'h1); tick(2);
        chk({ad_oe, ad_out}, 9'h15A);
        chk(ad_pullup, 8'h5A);
        apb(1, OFF_SPECIAL_FUNC_IO, 32'h58); tick(2);
        chk(ad_keeper_on, 1);
        s = strb_cnt; xfer(16'h1234, 0, 0, 0);
        chk({lat, acc_internal, acc_rdata, strb_cnt - s}, {32'd2, 9'h0, 32'd0});
        apb(1, OFF_MCU_CONTROL, 32'h3F); apb(0, OFF_MCU_CONTROL, 0); chk(rd, 32'h3F);
        apb(1, OFF_MCU_CONTROL, 32'h80);
        s = ale_cnt; xfer(16'h1234, 1, 8'hA5, 0);
        chk(lat, 5);
        chk(nbusy, 3);
        chk(ale_cnt - s, 1);
        chk({ale_oe, hi_oe}, 9'h11F);
        apb(1, OFF_SPECIAL_FUNC_IO, 32'h40);
        for (int c = 0; c < 4; c++) begin
            apb(1, OFF_MCU_CONTROL, 32'h80 | (c & 1) << 6);
            apb(1, OFF_EXT_MCU_CONTROL, c & 2);
            s = ale_cnt; xfer(16'h4000 + 16'(c), 1, 8'hC0 + 8'(c), c == 0);
            chk(lat, exp_lat(1, 2'(c)));
            chk(ale_cnt - s, c == 0 ? 2 : 1);
            xfer(16'h4000 + 16'(c), 0, 0, 0);
            chk(lat, exp_lat(0, 2'(c)));
            chk(acc_rdata, 8'hC0 + 8'(c));
        end
        apb(1, OFF_MCU_CONTROL, 32'h80);
        for (int l = 1; l < 8; l++) begin
            apb(1, OFF_EXT_MCU_CONTROL, l << 4 | 32'h8);
            xfer(16'(l * 32'h2000 - 1), 1, 8'h11, 0);
            chk(lat, exp_lat(1, WAIT_TWO));
            xfer(16'(l * 32'h2000), 1, 8'h22, 0);
            chk(lat, exp_lat(1, WAIT_NONE));
        end
        s = strb_cnt; xfer(INT_TOP_ADDR, 0, 0, 0);
        chk({lat, acc_internal, strb_cnt - s}, {32'd2, 1'b1, 32'd0});
        apb(0, OFF_STATUS, 0); chk(rd[3:0], 4'h8);
        xfer(INT_TOP_ADDR + 16'h1, 1, 8'h33, 0);
        chk({lat, acc_internal}, {32'd7, 1'b0});
        chk(overlap, 0);
        apb(1, OFF_HI_DIR, 32'h3C); apb(1, OFF_SPECIAL_FUNC_IO, 32'h78); tick(2);
        chk(hi_oe, 8'h3C);
        apb(1, OFF_MCU_CONTROL, 0); tick(2);
        chk({ale_oe, ad_oe, ad_out}, 10'h15A);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
